//--- src/nbm_top.sv
// top: national bit codeword monitor with Wishbone registers and interrupt
//
// Overview of operation
// - Each of Sa4..Sa8 yields a 4-bit codeword in its own read-only register.
// - With de-bounce on, store a codeword only after two equal sub-multiframes.
// - With de-bounce off, store every received codeword.
// - While multiframe sync is lost, stored codewords are frozen.
// - Control bit 6 turns codeword de-bounce on when 1, off when 0.
// - Alignment 0 compares any 12 Sa6 bits; 1 compares 3 aligned codewords.
// - Sa6 pattern comparison runs only while multiframe sync holds.
// - Hit bit 4 marks 0xFFF, hit bit 3 marks 0xEEE.
// - Hit bits 2, 1, 0 mark 0xCCC, 0xAAA, 0x888.
// - Summary special-code flag sets on any of the five pattern matches.
// - A change flag sets per stored codeword change, Sa4 at bit 4 to Sa8 at 0.
// - Enables in control bits 4..0 let change flags drive the interrupt low.
// - Control bit 5 lets the summary flag drive the interrupt.
// - Writing one clears an indication bit; writing zero leaves it.
//
// Chosen here: the Wishbone register port.
`timescale 1ns/1ps
module nbm_top
    import nbm_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [9:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic nat_valid,
    input wire logic nat_first,
    input wire logic [4:0] nat_bits,
    input wire logic crc_mf_sync,
    output logic irq_n
);
    typedef struct packed {
        logic [4:0][3:0] asm_cw;
        logic [2:0] cnt;
        logic cw_done;
        logic bit_valid;
        logic sa6_bit;
        logic ack;
        logic [31:0] dat;
        logic [7:0] ctrl;
        logic [4:0] pat_hits;
        logic [5:0] flags;
        logic irq_n;
    } nbm_top_st_t;
    nbm_top_st_t q;
    nbm_top_st_t nxt_q;

    nbm_if link ();
    logic req;
    logic wr;
    logic [7:0] idx;
    logic [7:0] rd_val;

    // register index from a byte address, used by read and write paths
    function automatic logic [7:0] reg_index(input logic [9:0] adr);
        reg_index = adr[9:2];
    endfunction

    // read multiplexer; unmapped indices answer zero
    function automatic logic [7:0] read_reg(input logic [7:0] i, input nbm_top_st_t s,
        input logic [4:0][3:0] cw);
        case (i)
            IDX_SA4_CW: read_reg = {4'h0, cw[4]};
            IDX_SA5_CW: read_reg = {4'h0, cw[3]};
            IDX_SA6_CW: read_reg = {4'h0, cw[2]};
            IDX_SA7_CW: read_reg = {4'h0, cw[1]};
            IDX_SA8_CW: read_reg = {4'h0, cw[0]};
            IDX_PAT_HITS: read_reg = {3'h0, s.pat_hits};
            IDX_IRQ_CTRL: read_reg = s.ctrl;
            IDX_IRQ_FLAGS: read_reg = {2'h0, s.flags};
            default: read_reg = 8'h00;
        endcase
    endfunction

    // bus decode; a write commits at the edge where ack is seen high
    assign req = wb_cyc_i && wb_stb_i;
    assign idx = reg_index(wb_adr_i);
    assign wr = req && wb_we_i && q.ack && wb_sel_i[0];
    assign rd_val = read_reg(idx, q, link.stored);

    always_comb
    begin
        logic [5:0] clr;
        logic [5:0] set;
        logic [4:0] pclr;
        clr = 6'h00;
        set = 6'h00;
        pclr = 5'h00;
        nxt_q = q;
        // codeword assembly: bit 1 of each word lands in the MSB
        nxt_q.cw_done = 1'b0;
        nxt_q.bit_valid = nat_valid;
        nxt_q.sa6_bit = nat_bits[POS_SA6];
        if (nat_valid)
        begin
            for (int i = 0; i < NBM_NUM_POS; i++)
                nxt_q.asm_cw[i] = nat_first ? {3'h0, nat_bits[i]} : {q.asm_cw[i][2:0], nat_bits[i]};
            nxt_q.cnt = nat_first ? 3'h1 : ((q.cnt == 3'h4) ? 3'h4 : q.cnt + 3'h1);
            // a partial first word after start-up never completes as a codeword
            nxt_q.cw_done = (nxt_q.cnt == 3'h4) && (nat_first || q.cnt == 3'h3);
        end
        // one-cycle ack, dropped in the cycle after it was given
        nxt_q.ack = req && !q.ack;
        if (req && !q.ack)
            nxt_q.dat = {24'h0, rd_val};
        if (wr)
        begin
            if (idx == IDX_IRQ_CTRL)
                nxt_q.ctrl = wb_dat_i[7:0];
            if (idx == IDX_IRQ_FLAGS || idx == IDX_IRQ_CLEAR)
                clr = wb_dat_i[5:0];
            if (idx == IDX_PAT_HITS)
                pclr = wb_dat_i[4:0];
        end
        // sticky flags: a set in the clearing cycle wins
        set = {|link.hits, link.changed};
        nxt_q.flags = (q.flags & ~clr) | set;
        nxt_q.pat_hits = (q.pat_hits & ~pclr) | link.hits;
        nxt_q.irq_n = ~|(nxt_q.flags & nxt_q.ctrl[5:0]);
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            q <= '0;
            q.ctrl <= CTRL_RESET;
            q.flags <= FLAGS_RESET;
            q.irq_n <= 1'b1;
        end
        else
        begin
            q <= nxt_q;
        end
    end

    // interface drive toward the store and the detector
    assign link.cw_done = q.cw_done;
    assign link.rx_cw = q.asm_cw;
    assign link.bit_valid = q.bit_valid;
    assign link.sa6_bit = q.sa6_bit;
    assign link.sync = crc_mf_sync;
    assign link.debounce_en = q.ctrl[CTRL_DEBOUNCE_BIT];
    assign link.align_sel = q.ctrl[CTRL_ALIGN_BIT];

    nbm_extract u_extract (
        .clk(clk),
        .rst(rst),
        .bus(link.ext)
    );

    nbm_pattern u_pattern (
        .clk(clk),
        .rst(rst),
        .bus(link.pat)
    );

    // outputs come straight from the state flops
    assign wb_dat_o = q.dat;
    assign wb_ack_o = q.ack;
    assign irq_n = q.irq_n;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    sequence flag_clear_s;
        wr && (idx == IDX_IRQ_FLAGS) && wb_dat_i[0];
    endsequence
    sequence no_set_s;
        !link.changed[0];
    endsequence
    ack_pulse_a: assert property (q.ack |=> !q.ack)
        else $error("ack stood longer than one cycle");
    irq_level_a: assert property (q.irq_n == !(|(q.flags & q.ctrl[5:0])))
        else $error("interrupt level disagrees with flags and enables");
    w1c_clear_a: assert property (flag_clear_s and no_set_s |=> !q.flags[0])
        else $error("write of one did not clear flag");
    w0_keep_a: assert property (wr && idx == IDX_IRQ_FLAGS && !wb_dat_i[0] && q.flags[0]
        |=> q.flags[0])
        else $error("write of zero cleared flag");
    change_sets_a: assert property (|link.changed |=> (q.flags[4:0] & $past(link.changed))
        == $past(link.changed))
        else $error("codeword change not flagged");
    special_sets_a: assert property (|link.hits |=> q.flags[FLAG_SPECIAL_BIT] &&
        ((q.pat_hits & $past(link.hits)) == $past(link.hits)))
        else $error("pattern hit not recorded");
    special_mask_a: assert property (!q.ctrl[CTRL_SPECIAL_EN_BIT] && q.ctrl[4:0] == 5'h00
        |-> q.irq_n)
        else $error("masked flags drove the interrupt");
    enable_irq_a: assert property (q.ctrl[0] && q.flags[0] |-> !q.irq_n)
        else $error("enabled change flag did not raise interrupt");
endmodule // nbm_top

//--- src/nbm_pkg.sv
// package: register map, field layout and pattern constants of the national bit monitor
package nbm_pkg;
    localparam int NBM_NUM_POS = 5;
    localparam int NBM_CW_BITS = 4;
    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_SA4_CW = 8'h56;
    localparam logic [7:0] IDX_SA5_CW = 8'h57;
    localparam logic [7:0] IDX_SA6_CW = 8'h58;
    localparam logic [7:0] IDX_SA7_CW = 8'h59;
    localparam logic [7:0] IDX_SA8_CW = 8'h5A;
    localparam logic [7:0] IDX_PAT_HITS = 8'h5B;
    localparam logic [7:0] IDX_IRQ_CTRL = 8'h5C;
    localparam logic [7:0] IDX_IRQ_FLAGS = 8'h5D;
    localparam logic [7:0] IDX_IRQ_CLEAR = 8'h70;
    // control register fields
    localparam int CTRL_ALIGN_BIT = 7;
    localparam int CTRL_DEBOUNCE_BIT = 6;
    localparam int CTRL_SPECIAL_EN_BIT = 5;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    // flag register: bit 5 summary, bits 4..0 change flags of Sa4..Sa8
    localparam int FLAG_SPECIAL_BIT = 5;
    localparam int FLAG_W = 6;
    localparam logic [5:0] FLAGS_RESET = 6'h00;
    localparam logic [4:0] HITS_RESET = 5'h00;
    // position of the Sa6 bit in the per-frame national bit vector
    localparam int POS_SA6 = 2;
    // special Sa6 patterns; hit vector order is F, E, C, A, 8 at bits 4..0
    localparam logic [11:0] PAT_F = 12'hFFF;
    localparam logic [11:0] PAT_E = 12'hEEE;
    localparam logic [11:0] PAT_C = 12'hCCC;
    localparam logic [11:0] PAT_A = 12'hAAA;
    localparam logic [11:0] PAT_8 = 12'h888;
    localparam logic [3:0] PAT_BITS = 4'hC;
    localparam logic [1:0] PAT_WORDS = 2'h3;
endpackage

//--- src/nbm_if.sv
// interface: assembled codewords and results shared by the monitor's modules
`timescale 1ns/1ps
interface nbm_if;
    logic cw_done;
    logic [4:0][3:0] rx_cw;
    logic bit_valid;
    logic sa6_bit;
    logic sync;
    logic debounce_en;
    logic align_sel;
    logic [4:0][3:0] stored;
    logic [4:0] changed;
    logic [4:0] hits;
    modport top (output cw_done, rx_cw, bit_valid, sa6_bit, sync, debounce_en, align_sel,
        input stored, changed, hits);
    modport ext (input cw_done, rx_cw, sync, debounce_en, output stored, changed);
    modport pat (input cw_done, rx_cw, bit_valid, sa6_bit, sync, align_sel, output hits);
endinterface

//--- src/nbm_extract.sv
// codeword store: per-position de-bounce, freeze and change detection
`timescale 1ns/1ps
module nbm_extract
    import nbm_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    nbm_if.ext bus
);
    typedef struct packed {
        logic [4:0][3:0] stored;
        logic [4:0][3:0] prev;
        logic prev_ok;
        logic [4:0] changed;
    } nbm_ext_st_t;
    nbm_ext_st_t q;
    nbm_ext_st_t nxt_q;

    // update happens only at a codeword boundary while multiframe sync holds
    always_comb
    begin
        nxt_q = q;
        nxt_q.changed = 5'h00;
        if (!bus.sync)
        begin
            nxt_q.prev_ok = 1'b0;
        end
        else if (bus.cw_done)
        begin
            for (int i = 0; i < NBM_NUM_POS; i++)
            begin
                // de-bounce needs the same word in two sub-multiframes
                if (!bus.debounce_en || (q.prev_ok && bus.rx_cw[i] == q.prev[i]))
                begin
                    nxt_q.stored[i] = bus.rx_cw[i];
                    nxt_q.changed[i] = (bus.rx_cw[i] != q.stored[i]);
                end
            end
            nxt_q.prev = bus.rx_cw;
            nxt_q.prev_ok = 1'b1;
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            q <= '0;
        else
            q <= nxt_q;
    end

    assign bus.stored = q.stored;
    assign bus.changed = q.changed;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    sequence load_nodeb_s;
        bus.cw_done && bus.sync && !bus.debounce_en;
    endsequence
    freeze_hold_a: assert property (!bus.sync |=> $stable(q.stored))
        else $error("codewords moved while sync lost");
    nodeb_load_a: assert property (load_nodeb_s |=> q.stored == $past(bus.rx_cw))
        else $error("codeword not loaded without de-bounce");
    deb_first_a: assert property (bus.cw_done && bus.sync && bus.debounce_en && !q.prev_ok
        |=> $stable(q.stored))
        else $error("codeword loaded after a single sub-multiframe");
endmodule // nbm_extract

//--- src/nbm_pattern.sv
// Sa6 special pattern detector, sliding-bit or codeword-aligned
`timescale 1ns/1ps
module nbm_pattern
    import nbm_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    nbm_if.pat bus
);
    typedef struct packed {
        logic [11:0] bits;
        logic [3:0] fill;
        logic [11:0] words;
        logic [1:0] nwords;
        logic [4:0] hits;
    } nbm_pat_st_t;
    nbm_pat_st_t q;
    nbm_pat_st_t nxt_q;

    // compare one 12-bit window against all five patterns
    function automatic logic [4:0] match(input logic [11:0] w);
        match = {w == PAT_F, w == PAT_E, w == PAT_C, w == PAT_A, w == PAT_8};
    endfunction

    always_comb
    begin
        nxt_q = q;
        nxt_q.hits = HITS_RESET;
        if (!bus.sync)
        begin
            // windows restart after sync so no stale bits join a match
            nxt_q.fill = 4'h0;
            nxt_q.nwords = 2'h0;
        end
        else if (!bus.align_sel && bus.bit_valid)
        begin
            nxt_q.bits = {q.bits[10:0], bus.sa6_bit};
            if (q.fill != PAT_BITS)
                nxt_q.fill = q.fill + 4'h1;
            if (nxt_q.fill == PAT_BITS)
                nxt_q.hits = match(nxt_q.bits);
        end
        else if (bus.align_sel && bus.cw_done)
        begin
            nxt_q.words = {q.words[7:0], bus.rx_cw[POS_SA6]};
            if (q.nwords != PAT_WORDS)
                nxt_q.nwords = q.nwords + 2'h1;
            if (nxt_q.nwords == PAT_WORDS)
                nxt_q.hits = match(nxt_q.words);
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            q <= '0;
        else
            q <= nxt_q;
    end

    assign bus.hits = q.hits;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    unsync_quiet_a: assert property (!bus.sync |=> q.hits == HITS_RESET)
        else $error("pattern hit reported without sync");
    fff_hit_a: assert property (q.hits[4] |-> $past(bus.align_sel) ? q.words == PAT_F
        : q.bits == PAT_F)
        else $error("all-ones hit without all-ones window");
endmodule // nbm_pattern

//--- test/nbm_top_bench.sv
// self-checking bench of the national bit monitor: register tasks, framer strobes, interrupt
`timescale 1ns/1ps
module nbm_top_bench
    import nbm_pkg::*;
;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [9:0] adr = 10'h000;
    logic [31:0] wdat = 32'h0000_0000;
    logic [31:0] rdat;
    logic ack;
    logic nat_valid = 1'b0;
    logic nat_first = 1'b0;
    logic [4:0] nat_bits = 5'h00;
    logic sync = 1'b0;
    logic irq_n;
    logic [7:0] q;
    logic [11:0] pats [5];
    int bad_count = 0;
    int tests_run = 0;

    // 250 MHz clock
    always #2 clk = ~clk;

    nbm_top u_dut (
        .clk(clk),
        .rst(rst),
        .wb_cyc_i(cyc),
        .wb_stb_i(stb),
        .wb_we_i(we),
        .wb_adr_i(adr),
        .wb_sel_i(4'hF),
        .wb_dat_i(wdat),
        .wb_dat_o(rdat),
        .wb_ack_o(ack),
        .nat_valid(nat_valid),
        .nat_first(nat_first),
        .nat_bits(nat_bits),
        .crc_mf_sync(sync),
        .irq_n(irq_n)
    );

    // compare and count
    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        tests_run++;
        if (got !== exp)
        begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask

    // classic cycle; request held until ack is sampled high, data taken at that edge
    task automatic wb(input logic w, input logic [7:0] idx, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {idx, 2'b00};
        wdat <= {24'h000000, d};
        do
        begin
            @(posedge clk);
            n++;
        end
        while (ack !== 1'b1 && n < 50);
        q = rdat[7:0];
        chk("upper data", 8'h00, rdat[31:24] | rdat[23:16] | rdat[15:8]);
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        if (n >= 50)
            chk("bus ack", 8'h01, 8'h00);
    endtask

    task automatic rd(input logic [7:0] idx, input logic [7:0] exp, input string name);
        wb(1'b0, idx, 8'h00);
        chk(name, exp, q);
    endtask

    // one sub-multiframe: four frames, codeword bits sent first bit first
    task automatic smf(input logic [19:0] cw);
        for (int i = 0; i < 4; i++)
        begin
            @(posedge clk);
            nat_valid <= 1'b1;
            nat_first <= (i == 0);
            for (int b = 0; b < 5; b++)
                nat_bits[b] <= cw[b * 4 + 3 - i];
        end
        @(posedge clk);
        nat_valid <= 1'b0;
        nat_first <= 1'b0;
        repeat (4) @(posedge clk);
    endtask

    // all five stored codewords, Sa4 in the top nibble
    task automatic cws(input logic [19:0] e);
        for (int p = 0; p < 5; p++)
            rd(IDX_SA4_CW + 8'(p), {4'h0, e[(4 - p) * 4 +: 4]}, "codeword");
    endtask

    // irq_n is registered; give the flag path time to settle
    task automatic irq(input logic e);
        repeat (3) @(posedge clk);
        chk("irq_n", {7'h00, e}, {7'h00, irq_n});
    endtask

    // dropping sync empties the pattern windows, so each pattern starts clean
    task automatic resync;
        @(posedge clk);
        sync <= 1'b0;
        repeat (3) @(posedge clk);
        sync <= 1'b1;
    endtask

    task automatic test_done;
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // main sequence
    initial
    begin
        pats = '{PAT_F, PAT_E, PAT_C, PAT_A, PAT_8};
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        for (int r = 0; r < 8; r++)
            rd(IDX_SA4_CW + 8'(r), 8'h00, "reset value");
        rd(8'h40, 8'h00, "unmapped");
        irq(1'b1);
        wb(1'b1, IDX_IRQ_CTRL, 8'h1F);
        rd(IDX_IRQ_CTRL, 8'h1F, "control");
        sync <= 1'b1;
        smf(20'h12345);
        cws(20'h12345);
        rd(IDX_IRQ_FLAGS, 8'h1F, "change flags");
        irq(1'b0);
        wb(1'b1, IDX_IRQ_FLAGS, 8'h00);
        rd(IDX_IRQ_FLAGS, 8'h1F, "flags kept");
        wb(1'b1, IDX_IRQ_FLAGS, 8'h15);
        rd(IDX_IRQ_FLAGS, 8'h0A, "flags part clear");
        wb(1'b1, IDX_IRQ_CLEAR, 8'h0A);
        rd(IDX_IRQ_FLAGS, 8'h00, "flags clear");
        irq(1'b1);
        smf(20'h12346);
        rd(IDX_IRQ_FLAGS, 8'h01, "last change");
        wb(1'b1, IDX_IRQ_FLAGS, 8'h01);
        wb(1'b1, IDX_IRQ_CTRL, 8'h1E);
        smf(20'h12347);
        rd(IDX_IRQ_FLAGS, 8'h01, "masked flag");
        irq(1'b1);
        wb(1'b1, IDX_IRQ_CTRL, 8'h1F);
        irq(1'b0);
        wb(1'b1, IDX_IRQ_FLAGS, 8'h3F);
        // de-bounce: one new word is not enough, two equal ones are
        wb(1'b1, IDX_IRQ_CTRL, 8'h5F);
        smf(20'hABCDE);
        cws(20'h12347);
        smf(20'hABCDE);
        cws(20'hABCDE);
        // history now holds 55555, so an unfrozen store would load the next equal word
        smf(20'h55555);
        sync <= 1'b0;
        smf(20'h55555);
        smf(20'h55555);
        cws(20'hABCDE);
        // history is dropped while unsynced, so one word after resync is not enough
        sync <= 1'b1;
        smf(20'h55555);
        cws(20'hABCDE);
        sync <= 1'b0;
        wb(1'b1, IDX_IRQ_CTRL, 8'hA0);
        repeat (3) smf(20'h00F00);
        rd(IDX_PAT_HITS, 8'h00, "hits without sync");
        wb(1'b0, IDX_IRQ_FLAGS, 8'h00);
        chk("summary without sync", 8'h00, q & 8'h20);
        // every pattern in both alignment modes
        for (int m = 0; m < 2; m++)
            for (int k = 0; k < 5; k++)
            begin
                wb(1'b1, IDX_IRQ_CTRL, {m[0], 7'h20});
                resync;
                repeat (3) smf({8'h00, pats[k][3:0], 8'h00});
                rd(IDX_PAT_HITS, 8'h10 >> k, "pattern hit");
                wb(1'b0, IDX_IRQ_FLAGS, 8'h00);
                chk("summary", 8'h20, q & 8'h20);
                irq(1'b0);
                wb(1'b1, IDX_PAT_HITS, 8'h1F);
                wb(1'b1, IDX_IRQ_FLAGS, 8'h3F);
                irq(1'b1);
            end
        // all-ones run straddling word boundaries: only the sliding window sees it
        for (int m = 0; m < 2; m++)
        begin
            wb(1'b1, IDX_IRQ_CTRL, {m[0], 7'h20});
            resync;
            smf(20'h00300);
            repeat (2) smf(20'h00F00);
            smf(20'h00C00);
            rd(IDX_PAT_HITS, m ? 8'h00 : 8'h10, "offset window");
            wb(1'b1, IDX_PAT_HITS, 8'h1F);
            wb(1'b1, IDX_IRQ_FLAGS, 8'h3F);
        end
        wb(1'b1, IDX_IRQ_CTRL, 8'h80);
        resync;
        repeat (3) smf(20'h00800);
        wb(1'b0, IDX_IRQ_FLAGS, 8'h00);
        chk("masked summary", 8'h20, q & 8'h20);
        irq(1'b1);
        test_done;
    end

    // watchdog well beyond the roughly one thousand cycles the sequence needs
    initial
    begin
        repeat (30000) @(posedge clk);
        chk("watchdog", 8'h01, 8'h00);
        test_done;
    end
endmodule // nbm_top_bench
